// [logic/ppm_pkg.sv]
// Package for the port pin override mux: widths, register offsets, reset values.
// Assumes an AXI4-Lite master with 32-bit data on the same clock.
package ppm_pkg;
  localparam int unsigned PPM_NPINS = 8;
  localparam logic [7:0] PPM_PINS_RST = 8'h00;
  localparam logic [11:0] PPM_OFS_DIR = 12'h000;
  localparam logic [11:0] PPM_OFS_LATCH = 12'h004;
  localparam logic [11:0] PPM_OFS_PIN = 12'h008;
  localparam logic [11:0] PPM_OFS_CTRL = 12'h00c;
  localparam logic [11:0] PPM_OFS_STAT = 12'h010;
  localparam int unsigned PPM_CTRL_PU_OFF_BIT = 0;
  localparam int unsigned PPM_STAT_DEEP_BIT = 0;
  localparam logic [1:0] PPM_RESP_OKAY = 2'b00;
  localparam logic [1:0] PPM_RESP_SLVERR = 2'b10;
  localparam logic [31:0] PPM_ZERO32 = 32'h0000_0000;
  // Port B alternate function positions; every pin is also a pin-change source
  localparam int unsigned PPM_PB_TIMER2_COMPARE_A_OUT = 3;
  localparam int unsigned PPM_PB_TIMER1_COMPARE_B_OUT = 2;
  localparam int unsigned PPM_PB_DIVIDED_CLOCK_OUT = 0;
  localparam int unsigned PPM_PB_MAIN_OSC_OUT = 7;
  localparam int unsigned PPM_PB_MAIN_OSC_IN = 6;
  localparam int unsigned PPM_PB_SPI_SCK = 5;
  localparam int unsigned PPM_PB_SPI_MISO = 4;
  localparam int unsigned PPM_PB_SPI_MOSI = 3;
  localparam int unsigned PPM_PB_SPI_SS = 2;
  localparam int unsigned PPM_PB_TIMER1_COMPARE_A_OUT = 1;
  localparam int unsigned PPM_PB_TIMER1_CAPTURE_IN = 0;
endpackage

// [logic/ppm_ovr_if.sv]
// Override bundle between the port top and the per-pin mixer.
// Assumes all signals belong to the core clock domain.
`timescale 1ns/1ps
`default_nettype none
interface ppm_ovr_if;
  import ppm_pkg::*;
  logic [PPM_NPINS-1:0] pullup_override_en;
  logic [PPM_NPINS-1:0] pullup_override_val;
  logic [PPM_NPINS-1:0] direction_override_en;
  logic [PPM_NPINS-1:0] direction_override_val;
  logic [PPM_NPINS-1:0] pin_value_override_en;
  logic [PPM_NPINS-1:0] pin_value_override_val;
  logic [PPM_NPINS-1:0] input_enable_override_en;
  logic [PPM_NPINS-1:0] input_enable_override_val;
  logic [PPM_NPINS-1:0] direction_bit;
  logic [PPM_NPINS-1:0] output_latch_bit;
  logic [PPM_NPINS-1:0] irq_enable;
  logic global_pullup_disable;
  logic deep_sleep;
  logic in_reset;
  logic [PPM_NPINS-1:0] pad_out;
  logic [PPM_NPINS-1:0] pad_oe;
  logic [PPM_NPINS-1:0] pad_pullup;
  logic [PPM_NPINS-1:0] input_enable;
  modport top (output pullup_override_en, pullup_override_val, direction_override_en,
    direction_override_val, pin_value_override_en, pin_value_override_val,
    input_enable_override_en, input_enable_override_val, direction_bit, output_latch_bit,
    irq_enable, global_pullup_disable, deep_sleep, in_reset,
    input pad_out, pad_oe, pad_pullup, input_enable);
  modport mix (input pullup_override_en, pullup_override_val, direction_override_en,
    direction_override_val, pin_value_override_en, pin_value_override_val,
    input_enable_override_en, input_enable_override_val, direction_bit, output_latch_bit,
    irq_enable, global_pullup_disable, deep_sleep, in_reset,
    output pad_out, pad_oe, pad_pullup, input_enable);
endinterface
`default_nettype wire

// [logic/ppm_pin_mix.sv]
// Combinational per-pin override mixer.
// Assumes the top feeds register state and alternate-function overrides.
`timescale 1ns/1ps
`default_nettype none
module ppm_pin_mix
  import ppm_pkg::*;
(
  ppm_ovr_if.mix ov
);
  for (genvar i = 0; i < PPM_NPINS; i++) begin : g_pin
    logic sw_pu;
    assign sw_pu = ~ov.direction_bit[i] & ov.output_latch_bit[i] & ~ov.global_pullup_disable;
    // Pull-up never on in reset, whatever software set
    assign ov.pad_pullup[i] = ~ov.in_reset &
      (ov.pullup_override_en[i] ? ov.pullup_override_val[i] : sw_pu);
    assign ov.pad_oe[i] = ~ov.in_reset &
      (ov.direction_override_en[i] ? ov.direction_override_val[i]
                                   : ov.direction_bit[i]);
    assign ov.pad_out[i] = ov.pin_value_override_en[i] ? ov.pin_value_override_val[i]
                                                       : ov.output_latch_bit[i];
    // Interrupt-enabled pins escape the clamp
    assign ov.input_enable[i] = ov.input_enable_override_en[i] ? ov.input_enable_override_val[i]
                                : (~ov.deep_sleep | ov.irq_enable[i]);
  end
endmodule
`default_nettype wire

// [logic/ppm_port.sv]
// Eight-pin port with alternate-function overrides and an AXI4-Lite register slave.
// Assumes pads and alternate functions outside; pad analog path wired outside this logic.
// How it works
// - Deep sleep modes clamp the digital input to ground before the Schmitt trigger.
// - Pins with an enabled external interrupt stay unclamped in deep sleep.
// - Interrupt-capable pins with interrupt disabled are clamped like any pin.
// - High level on a disabled edge interrupt pin sets its flag on wake.
// - All pull-ups stay off while reset is active.
// - Without override, pull-up is on only for direction/latch/disable equal 010.
// - Pull-up override on: override value alone turns the pull-up on or off.
// - Driver enable follows direction override value when enabled, else direction bit.
// - Direction override on: driver on for one, off for zero.
// - Driven level from pin-value override when enabled, else from the latch bit.
// - Pin-value override on: latch contents are ignored.
// - Toggle override enable inverts the stored output latch bit.
// - Input enable follows its override when enabled, else the sleep state.
// - Input enable override value one enables, zero disables, in any state.
// - Alternate functions get the Schmitt output before the port synchroniser.
// - A bidirectional analog path goes straight to the pad.
// - Port B: oscillator, SPI, timer compare, capture, clock out, pin-change on all.
// - Direction one drives the latch; input with latch one enables pull-up.
// - Writing one to the pin input bit toggles the output latch bit.
// - Pin input bit is read through a two-stage synchroniser.
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ppm_port
  import ppm_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  output logic [7:0] pad_pullup,
  output logic [7:0] input_enable,
  output logic [7:0] raw_schmitt_input,
  input wire logic deep_sleep,
  input wire logic [7:0] irq_enable,
  input wire logic [7:0] irq_edge_mode,
  output logic [7:0] wake_irq_flag_set,
  input wire logic [7:0] pullup_override_en,
  input wire logic [7:0] pullup_override_val,
  input wire logic [7:0] direction_override_en,
  input wire logic [7:0] direction_override_val,
  input wire logic [7:0] pin_value_override_en,
  input wire logic [7:0] pin_value_override_val,
  input wire logic [7:0] latch_toggle_override_en,
  input wire logic [7:0] input_enable_override_en,
  input wire logic [7:0] input_enable_override_val
);
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] latch;
    logic pu_off;
    logic [7:0] sync1;
    logic [7:0] pin_in;
    logic [7:0] pad_s1;
    logic [7:0] pad_s2;
    logic sleep;
    logic [7:0] wake;
    logic aw_hold;
    logic [11:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ppm_state_t;

  ppm_state_t q, d;
  ppm_ovr_if ov();

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == PPM_OFS_DIR) || (a == PPM_OFS_LATCH) || (a == PPM_OFS_PIN) ||
                 (a == PPM_OFS_CTRL) || (a == PPM_OFS_STAT);
  endfunction

  function automatic logic [31:0] read_word(input logic [11:0] a, input ppm_state_t s);
    logic [31:0] w;
    w = PPM_ZERO32;
    case (a)
      PPM_OFS_DIR: begin
        w[PPM_NPINS-1:0] = s.dir;
      end
      PPM_OFS_LATCH: begin
        w[PPM_NPINS-1:0] = s.latch;
      end
      PPM_OFS_PIN: begin
        w[PPM_NPINS-1:0] = s.pin_in;
      end
      PPM_OFS_CTRL: begin
        w[PPM_CTRL_PU_OFF_BIT] = s.pu_off;
      end
      PPM_OFS_STAT: begin
        w[PPM_STAT_DEEP_BIT] = s.sleep;
      end
      // Unmapped offsets read as zero beside their error response
      default: begin
        w = PPM_ZERO32;
      end
    endcase
    read_word = w;
  endfunction

  // Clamp release on a disabled edge pin reads as a rising edge
  logic [7:0] wake_hit;
  for (genvar i = 0; i < PPM_NPINS; i++) begin : g_wake
    assign wake_hit[i] = q.sleep & ~deep_sleep & ~irq_enable[i] & irq_edge_mode[i] &
                         q.pad_s2[i] & ~input_enable_override_en[i];
  end

  // Alternate functions drive these; tied-low enables leave the pin to software
  assign ov.pullup_override_en = pullup_override_en;
  assign ov.pullup_override_val = pullup_override_val;
  assign ov.direction_override_en = direction_override_en;
  assign ov.direction_override_val = direction_override_val;
  assign ov.pin_value_override_en = pin_value_override_en;
  assign ov.pin_value_override_val = pin_value_override_val;
  assign ov.input_enable_override_en = input_enable_override_en;
  assign ov.input_enable_override_val = input_enable_override_val;
  assign ov.direction_bit = q.dir;
  assign ov.output_latch_bit = q.latch;
  assign ov.irq_enable = irq_enable;
  assign ov.global_pullup_disable = q.pu_off;
  assign ov.deep_sleep = q.sleep;
  assign ov.in_reset = srst;

  ppm_pin_mix u_mix (
    .ov(ov)
  );

  assign pad_out = ov.pad_out;
  assign pad_oe = ov.pad_oe;
  assign pad_pullup = ov.pad_pullup;
  assign input_enable = ov.input_enable;
  // Clamped pad before the synchroniser; consumers must synchronise it
  assign raw_schmitt_input = pad_in & ov.input_enable;
  // The analog pad path is a bare wire at the pad ring; no logic here touches it
  assign wake_irq_flag_set = q.wake;

  assign s_axi_awready = ~q.aw_hold;
  assign s_axi_wready = ~q.w_hold;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  always_comb begin
    logic [7:0] wbyte;
    logic do_wr;
    wbyte = 8'h00;
    do_wr = 1'b0;
    d = q;
    if (clk_en) begin
      // Two flops; the second stage alone is read
      d.sync1 = raw_schmitt_input;
      d.pin_in = q.sync1;
      // Wake logic sees the pad level only through its own two flops
      d.pad_s1 = pad_in;
      d.pad_s2 = q.pad_s1;
      d.sleep = deep_sleep;
      d.wake = wake_hit;
      d.latch = q.latch ^ latch_toggle_override_en;
      if (s_axi_awvalid && !q.aw_hold) begin
        d.aw_hold = 1'b1;
        d.aw_addr = s_axi_awaddr[11:0];
      end
      if (s_axi_wvalid && !q.w_hold) begin
        d.w_hold = 1'b1;
        d.w_data = s_axi_wdata;
        d.w_strb = s_axi_wstrb;
      end
      if (q.aw_hold && q.w_hold && !q.bvalid) begin
        do_wr = q.w_strb[0];
        wbyte = q.w_data[7:0];
        d.aw_hold = 1'b0;
        d.w_hold = 1'b0;
        d.bvalid = 1'b1;
        d.bresp = addr_known(q.aw_addr) ? PPM_RESP_OKAY : PPM_RESP_SLVERR;
        if (do_wr) begin
          case (q.aw_addr)
            PPM_OFS_DIR: begin
              d.dir = wbyte;
            end
            // A toggle override in the write cycle still flips the new value
            PPM_OFS_LATCH: begin
              d.latch = wbyte ^ latch_toggle_override_en;
            end
            PPM_OFS_PIN: begin
              d.latch = q.latch ^ wbyte ^ latch_toggle_override_en;
            end
            PPM_OFS_CTRL: begin
              d.pu_off = wbyte[PPM_CTRL_PU_OFF_BIT];
            end
            default: ;
          endcase
        end
      end
      if (q.bvalid && s_axi_bready) begin
        d.bvalid = 1'b0;
      end
      if (s_axi_arvalid && !q.rvalid) begin
        d.rvalid = 1'b1;
        d.rresp = addr_known(s_axi_araddr[11:0]) ? PPM_RESP_OKAY : PPM_RESP_SLVERR;
        d.rdata = read_word(s_axi_araddr[11:0], q);
      end else if (q.rvalid && s_axi_rready) begin
        d.rvalid = 1'b0;
      end
    end
  end

  // Reset tri-states every pin by gating pad_oe with in_reset, direction overrides included
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// [dv/ppm_port_sva.sv]
// Checker on the port pin override mux top ports.
// Assumes a bind from the bench and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ppm_port_sva (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] pad_in,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  input wire logic [7:0] input_enable,
  input wire logic [7:0] raw_schmitt_input,
  input wire logic deep_sleep,
  input wire logic [7:0] irq_enable,
  input wire logic [7:0] wake_irq_flag_set,
  input wire logic [7:0] pullup_override_en,
  input wire logic [7:0] pullup_override_val,
  input wire logic [7:0] direction_override_en,
  input wire logic [7:0] direction_override_val,
  input wire logic [7:0] pin_value_override_en,
  input wire logic [7:0] pin_value_override_val,
  input wire logic [7:0] input_enable_override_en,
  input wire logic [7:0] input_enable_override_val
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  a_reset_quiet: assert property (disable iff (1'b0)
    srst |-> pad_oe == 8'h00 && pad_pullup == 8'h00) else $error("pad active in reset");
  a_pullup_ovr: assert property (
    ((pad_pullup ^ pullup_override_val) & pullup_override_en) == 8'h00)
    else $error("pull-up ignores override");
  a_dir_ovr: assert property (
    ((pad_oe ^ direction_override_val) & direction_override_en) == 8'h00)
    else $error("driver ignores override");
  a_value_ovr: assert property (
    ((pad_out ^ pin_value_override_val) & pin_value_override_en & pad_oe) == 8'h00)
    else $error("level ignores override");
  a_ie_ovr: assert property (
    ((input_enable ^ input_enable_override_val) & input_enable_override_en) == 8'h00)
    else $error("input enable ignores override");
  a_awake_live: assert property (!deep_sleep && !$past(deep_sleep) |->
    (input_enable | input_enable_override_en) == 8'hff) else $error("input clamped awake");
  a_sleep_clamp: assert property (deep_sleep && $past(deep_sleep) |->
    (input_enable & ~irq_enable & ~input_enable_override_en) == 8'h00) else $error("no clamp");
  a_irq_live: assert property (deep_sleep && $past(deep_sleep) |->
    (~input_enable & irq_enable & ~input_enable_override_en) == 8'h00) else $error("irq clamped");
  a_schmitt_raw: assert property (raw_schmitt_input == (pad_in & input_enable))
    else $error("raw input wrong");
  a_wake_pulse: assert property (|wake_irq_flag_set |-> !deep_sleep &&
    (wake_irq_flag_set & irq_enable) == 8'h00 ##1 wake_irq_flag_set == 8'h00)
    else $error("wake flag wrong");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  c_sleep: cover property (deep_sleep ##1 !deep_sleep);
  c_wake: cover property (|wake_irq_flag_set);
  c_write: cover property (s_axi_bvalid);
endmodule
`default_nettype wire

// [dv/ppm_pad_model.sv]
// Pad model: resolves each pin from driver, external source and pull-up.
// Assumes the bench sets ext_en and ext_val; the analog path is not modelled.
`timescale 1ns/1ps
`default_nettype none
module ppm_pad_model (
  input wire logic clk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  logic [7:0] float_q = 8'h00;
  // A floating pin flips every cycle, so a stale level never passes as a match
  always_ff @(posedge clk) float_q <= ~pad_in;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
    (~pad_oe & ~ext_en & (pad_pullup | float_q));
endmodule
`default_nettype wire

// [dv/test_ppm_port.sv]
// Bench for the port pin override mux: AXI4-Lite master, pad model, overrides.
// Assumes ppm_pkg offsets and the checker bound below.
`timescale 1ns/1ps
`default_nettype none
module test_ppm_port;
  import ppm_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, deep_sleep = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] irq_enable = 8'h00, irq_edge_mode = 8'h00, latch_toggle_override_en = 8'h00;
  logic [7:0] pullup_override_en = 8'hff, pullup_override_val = 8'hff, ext_en = 8'h00;
  logic [7:0] direction_override_en = 8'hff, direction_override_val = 8'hff, ext_val = 8'h00;
  logic [7:0] pin_value_override_en = 8'h00, pin_value_override_val = 8'h00;
  logic [7:0] input_enable_override_en = 8'h00, input_enable_override_val = 8'h00;
  logic [7:0] pad_in, pad_out, pad_oe, pad_pullup, input_enable, raw_schmitt_input;
  logic [7:0] wake_irq_flag_set;
  int num_errors = 0;
  int tests_run = 0;
  logic [1:0] last_bresp = 2'h3;
  ppm_port u_ppm_port (.*);
  ppm_pad_model u_ppm_pad_model (.clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
  always #25 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Handshakes are sampled at the falling edge, where the slave's outputs are settled
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d);
    logic aw, w, b;
    b = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= {20'h0, a};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge core_clk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid & s_axi_bready;
      last_bresp = s_axi_bresp;
      @(posedge core_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rv;
    rv = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= {20'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rv) begin
      @(negedge core_clk);
      ar = s_axi_arvalid & s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic t_gpio;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(PPM_OFS_DIR, 8'h0f);
    chk(last_bresp, PPM_RESP_OKAY);
    axi_wr(PPM_OFS_LATCH, 8'ha5);
    @(negedge core_clk);
    chk(pad_oe, 8'h0f);
    chk(pad_out & pad_oe, 8'h05);
    chk(pad_pullup, 8'ha0);
    axi_wr(PPM_OFS_CTRL, 8'h01);
    @(negedge core_clk);
    chk(pad_pullup, 8'h00);
    axi_wr(PPM_OFS_CTRL, 8'h00);
    axi_wr(PPM_OFS_PIN, 8'h0f);
    axi_rd(PPM_OFS_LATCH, d, r);
    chk(d, 32'haa);
    chk(r, PPM_RESP_OKAY);
    axi_rd(PPM_OFS_DIR, d, r);
    chk(d, 32'h0f);
    axi_wr(12'h020, 8'hff);
    chk(last_bresp, PPM_RESP_SLVERR);
    axi_rd(12'h020, d, r);
    chk(r, PPM_RESP_SLVERR);
    chk(d, PPM_ZERO32);
  endtask
  task automatic t_ovr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge core_clk);
    pullup_override_en <= 8'hff;
    pullup_override_val <= 8'h3c;
    direction_override_en <= 8'hf0;
    direction_override_val <= 8'h50;
    pin_value_override_en <= 8'hff;
    pin_value_override_val <= 8'h33;
    @(negedge core_clk);
    chk(pad_pullup, 8'h3c);
    chk(pad_oe, 8'h5f);
    chk(pad_out & pad_oe, 8'h13);
    @(posedge core_clk);
    pullup_override_en <= 8'h00;
    direction_override_en <= 8'h00;
    pin_value_override_en <= 8'h00;
    latch_toggle_override_en <= 8'h01;
    @(posedge core_clk);
    latch_toggle_override_en <= 8'h00;
    ext_en <= 8'hf0;
    ext_val <= 8'h90;
    axi_rd(PPM_OFS_LATCH, d, r);
    chk(d, 32'hab);
    axi_rd(PPM_OFS_PIN, d, r);
    chk(d, 32'h9b);
    // Clock enable low: the toggle override must not reach the latch
    @(posedge core_clk);
    clk_en <= 1'b0;
    latch_toggle_override_en <= 8'hff;
    repeat (3) @(posedge core_clk);
    clk_en <= 1'b1;
    latch_toggle_override_en <= 8'h00;
    axi_rd(PPM_OFS_LATCH, d, r);
    chk(d, 32'hab);
  endtask
  task automatic t_sleep;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] flag;
    axi_wr(PPM_OFS_DIR, 8'h00);
    ext_en <= 8'hff;
    ext_val <= 8'h01;
    irq_edge_mode <= 8'h01;
    irq_enable <= 8'h02;
    input_enable_override_en <= 8'h0c;
    input_enable_override_val <= 8'h04;
    deep_sleep <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(input_enable, 8'h06);
    chk(raw_schmitt_input, 8'h00);
    axi_rd(PPM_OFS_STAT, d, r);
    chk(d, 32'h1);
    @(posedge core_clk);
    input_enable_override_en <= 8'h00;
    deep_sleep <= 1'b0;
    flag = 8'h00;
    repeat (6) begin
      @(negedge core_clk);
      flag = flag | wake_irq_flag_set;
    end
    chk(flag, 8'h01);
    chk(input_enable, 8'hff);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk(pad_pullup, 8'h00);
    chk(pad_oe, 8'h00);
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    pullup_override_en <= 8'h00;
    direction_override_en <= 8'h00;
    t_gpio();
    t_ovr();
    t_sleep();
    report_and_stop();
  end
  // Whole run is under a hundred cycles; this bound only cuts a hang
  initial begin
    #250000;
    num_errors++;
    report_and_stop();
  end
endmodule
bind ppm_port ppm_port_sva u_ppm_port_sva (.*);
`default_nettype wire
